// [board_strap_glue.sv]
// strap-configured glue: bus reset, slave modifier match, memory decode and pacing, dma routing
//
// Behaviour
// - a local reset drives the backplane bus reset only while the propagate strap is enabled.
// - the dual-ported RAM slave answers only when modifier lines 5 to 3 are all high.
// - each of modifier lines 2 to 0 is compared with its strap: must be low, ignored, or high.
// - a modifier strap left open requires that modifier line to be high.
// - block-transfer modifier codes never select the slave; only single transfers do.
// - straps ignore, low, high on lines 2, 1, 0 match codes 3D and 39 both.
// - fast memory timing acknowledges right after the memory select, with no wait cycle.
// - slow memory timing, the open-strap default, acknowledges four clocks after select.
// - static RAM and EPROM take their timing from separate straps.
// - first-tier devices of each socket pair sit at the lower addresses, second tier above.
// - the upper byte lane selects one socket column and the lower lane the other.
// - the decoder spans 256 Kbyte of EPROM and 128 Kbyte of RAM in four byte-wide parts each.
// - full-duplex routing puts port A receive on channel 2 and port A transmit on channel 3.
// - half-duplex routing shares channel 2 for port A and channel 3 for port B.
// - the two routing straps act as one setting; a mixed setting routes nothing.
module board_strap_glue
  import strap_glue_pkg::*;
#(
  parameter logic [23:0] EPROM_BASE = 24'h00_0000,
  parameter logic [23:0] RAM_BASE   = 24'h04_0000
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // straps
  input  wire logic        bus_reset_propagate_strap,
  input  wire logic [5:0]  modifier_match_straps,
  input  wire logic [1:0]  memory_wait_straps,
  input  wire logic        dma_route_strap_first,
  input  wire logic        dma_route_strap_second,
  // reset
  input  wire logic        local_reset_req,
  output logic             bus_reset_q,
  // backplane slave
  input  wire logic        vme_addr_hit,
  input  wire logic [5:0]  vme_am,
  output logic             dpram_sel_q,
  // local processor bus
  input  wire logic [23:1] cpu_addr,
  input  wire logic        cpu_strobe,
  input  wire logic        cpu_upper,
  input  wire logic        cpu_lower,
  output logic [3:0]       mem_sel_hi_q,
  output logic [3:0]       mem_sel_lo_q,
  output logic             mem_ack_q,
  // serial dma
  input  wire logic        ser_a_rx_req,
  input  wire logic        ser_a_tx_req,
  input  wire logic        ser_b_req,
  input  wire logic        dma_ch2_ack,
  input  wire logic        dma_ch3_ack,
  output logic             dma_ch2_req_q,
  output logic             dma_ch3_req_q,
  output logic             ser_a_rx_ack_q,
  output logic             ser_a_tx_ack_q,
  output logic             ser_b_ack_q,
  // register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [7:0]       reg_rdata_q
);

  // ************************************************************
  // pin synchronisers
  // ************************************************************
  localparam int SW = 24;

  logic [SW-1:0] sync1_q;
  logic [SW-1:0] sync2_q;

  // not reset: straps must be sampled during reset to steer the bus reset
  always_ff @(posedge sys_clk) begin
    sync1_q <= {bus_reset_propagate_strap, modifier_match_straps, memory_wait_straps,
                dma_route_strap_first, dma_route_strap_second, local_reset_req,
                vme_addr_hit, vme_am, ser_a_rx_req, ser_a_tx_req, ser_b_req,
                dma_ch2_ack, dma_ch3_ack};
    sync2_q <= sync1_q;
  end

  logic       prop_s;
  logic [5:0] am_st_s;
  logic [1:0] wait_st_s;
  logic       route1_s;
  logic       route2_s;
  logic       lrst_s;
  logic       hit_s;
  logic [5:0] am_s;
  logic       a_rx_s;
  logic       a_tx_s;
  logic       b_req_s;
  logic       ch2_ack_s;
  logic       ch3_ack_s;

  assign {prop_s, am_st_s, wait_st_s, route1_s, route2_s, lrst_s, hit_s, am_s,
          a_rx_s, a_tx_s, b_req_s, ch2_ack_s, ch3_ack_s} = sync2_q;

  // ************************************************************
  // control register
  // ************************************************************
  logic [7:0] ctrl_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
    end else if (reg_wr && reg_addr == REG_CTRL) begin
      ctrl_q <= reg_wdata;
    end
  end

  // ************************************************************
  // backplane reset
  // ************************************************************
  always_ff @(posedge sys_clk) begin
    bus_reset_q <= prop_s && (rst || lrst_s);
  end

  // ************************************************************
  // slave modifier match
  // ************************************************************
  function automatic logic am_match(input logic [5:0] am, input logic [5:0] st);
    logic ok;
    ok = (am[5:3] == AM_UPPER_STD);
    ok = ok && am[1:0] != AM_LOW_BLOCK && am[1:0] != AM_LOW_MULTI;
    for (int i = 0; i < 3; i++) begin
      if (st[2*i +: 2] == AM_STRAP_LOW) begin
        ok = ok && !am[i];
      end else if (st[2*i +: 2] != AM_STRAP_ANY) begin
        ok = ok && am[i];
      end
    end
    return ok;
  endfunction

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dpram_sel_q <= 1'b0;
    end else begin
      dpram_sel_q <= hit_s && ctrl_q[CTRL_SLAVE_EN] && am_match(am_s, am_st_s);
    end
  end

  // ************************************************************
  // local memory decode
  // ************************************************************
  // blocks 0,1: eprom tiers; blocks 2,3: ram tiers
  logic eprom_hit;
  logic ram_hit;
  logic [3:0] blk;

  assign eprom_hit = cpu_strobe && cpu_addr[23:18] == EPROM_BASE[23:18];
  assign ram_hit   = cpu_strobe && cpu_addr[23:17] == RAM_BASE[23:17];

  always_comb begin
    blk = 4'h0;
    if (eprom_hit) begin
      blk[cpu_addr[EPROM_TIER_BIT] ? 1 : 0] = 1'b1;
    end else if (ram_hit) begin
      blk[cpu_addr[RAM_TIER_BIT] ? 3 : 2] = 1'b1;
    end
  end

  logic mem_fast_q;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mem_sel_hi_q <= 4'h0;
      mem_sel_lo_q <= 4'h0;
      mem_fast_q   <= 1'b0;
    end else begin
      mem_sel_hi_q <= cpu_upper ? blk : 4'h0;
      mem_sel_lo_q <= cpu_lower ? blk : 4'h0;
      // a fitted jumper reads low and selects fast timing
      mem_fast_q <= !ctrl_q[CTRL_FORCE_SLOW] &&
                    (ram_hit ? !wait_st_s[WAIT_RAM_BIT] : !wait_st_s[WAIT_EPROM_BIT]);
    end
  end

  logic mem_any;
  logic mem_busy_q;

  assign mem_any = |(mem_sel_hi_q | mem_sel_lo_q);

  mem_wait_timer #(
    .DELAY (SLOW_ACK_CYCLES)
  ) u_wait (
    .sys_clk (sys_clk),
    .rst     (rst),
    .mem_sel (mem_any),
    .fast    (mem_fast_q),
    .ack_q   (mem_ack_q),
    .busy_q  (mem_busy_q)
  );

  // ************************************************************
  // serial dma routing
  // ************************************************************
  logic mixed;
  logic full;

  assign mixed = route1_s != route2_s;
  assign full  = route1_s && !mixed;

  always_ff @(posedge sys_clk) begin
    if (rst || mixed) begin
      dma_ch2_req_q  <= 1'b0;
      dma_ch3_req_q  <= 1'b0;
      ser_a_rx_ack_q <= 1'b0;
      ser_a_tx_ack_q <= 1'b0;
      ser_b_ack_q    <= 1'b0;
    end else if (full) begin
      dma_ch2_req_q  <= a_rx_s;
      dma_ch3_req_q  <= a_tx_s;
      ser_a_rx_ack_q <= ch2_ack_s;
      ser_a_tx_ack_q <= ch3_ack_s;
      ser_b_ack_q    <= 1'b0;
    end else begin
      // shared request and acknowledge pins carry both directions
      dma_ch2_req_q  <= a_rx_s;
      dma_ch3_req_q  <= b_req_s;
      ser_a_rx_ack_q <= ch2_ack_s;
      ser_a_tx_ack_q <= 1'b0;
      ser_b_ack_q    <= ch3_ack_s;
    end
  end

  // ************************************************************
  // register read port
  // ************************************************************
  logic [7:0] status;

  always_comb begin
    status                = 8'h00;
    status[ST_RESET_PROP] = prop_s;
    status[ST_DMA_FULL]   = full;
    status[ST_DMA_MIXED]  = mixed;
    status[ST_RAM_FAST]   = !wait_st_s[WAIT_RAM_BIT];
    status[ST_EPROM_FAST] = !wait_st_s[WAIT_EPROM_BIT];
    status[ST_MEM_BUSY]   = mem_busy_q;
    status[ST_SLAVE_SEL]  = dpram_sel_q;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd && reg_addr == REG_CTRL) begin
      reg_rdata_q <= ctrl_q;
    end else if (reg_rd && reg_addr == REG_STATUS) begin
      reg_rdata_q <= status;
    end else if (reg_rd && reg_addr == REG_AM_STRAPS) begin
      reg_rdata_q <= {2'b00, am_st_s};
    end else begin
      reg_rdata_q <= 8'h00;
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_bus_reset_on: assert property (prop_s && lrst_s |=> bus_reset_q)
    else $error("bus reset not driven on local reset");
  a_bus_reset_off: assert property (!prop_s |=> !bus_reset_q)
    else $error("bus reset driven while strap disabled");
  a_am_upper: assert property (dpram_sel_q |-> $past(am_s[5:3]) == AM_UPPER_STD)
    else $error("slave selected with upper modifier lines not high");
  a_am_low_strap: assert property (am_st_s[1:0] == AM_STRAP_LOW && am_s[0]
    |=> !dpram_sel_q)
    else $error("slave selected against low strap");
  a_am_open_strap: assert property (am_st_s[5:4] == AM_STRAP_OPEN && !am_s[2]
    |=> !dpram_sel_q)
    else $error("open strap did not require line high");
  a_no_block: assert property (am_s[1:0] == AM_LOW_BLOCK |=> !dpram_sel_q)
    else $error("slave selected on block transfer code");
  a_std_codes: assert property (am_st_s == {AM_STRAP_ANY, AM_STRAP_LOW, AM_STRAP_OPEN}
    && hit_s && ctrl_q[CTRL_SLAVE_EN] && (am_s == 6'h3D || am_s == 6'h39)
    |=> dpram_sel_q)
    else $error("standard data code not matched");
  a_fast_ack: assert property ($rose(mem_any) && mem_fast_q |=> mem_ack_q)
    else $error("fast access not acknowledged at once");
  a_slow_hold: assert property ($rose(mem_any) && !mem_fast_q |-> !mem_ack_q [*4])
    else $error("slow access acknowledged early");
  a_slow_ack: assert property ($rose(mem_any) && !mem_fast_q ##1 mem_any [*3]
    |=> mem_ack_q)
    else $error("slow access not acknowledged after four cycles");
  a_ack_drop: assert property (!mem_any |=> !mem_ack_q)
    else $error("acknowledge held after select released");
  a_lane_split: assert property (|mem_sel_hi_q |-> $past(cpu_upper))
    else $error("upper lane selected without upper strobe");
  a_eprom_tier: assert property (mem_sel_hi_q[1] || mem_sel_lo_q[1]
    |-> $past(cpu_addr[EPROM_TIER_BIT]))
    else $error("second eprom tier selected at lower address");
  a_full_route: assert property (full |=> dma_ch3_req_q == $past(a_tx_s))
    else $error("full duplex transmit not on channel 3");
  a_half_route: assert property (!route1_s && !route2_s
    |=> dma_ch3_req_q == $past(b_req_s))
    else $error("half duplex port b not on channel 3");
  a_mixed_route: assert property (mixed |=> !dma_ch2_req_q && !dma_ch3_req_q)
    else $error("mixed routing passed a request");

  c_slave_hit: cover property (dpram_sel_q);
  c_slow_access: cover property ($rose(mem_any) && !mem_fast_q ##4 mem_ack_q);
  c_fast_access: cover property ($rose(mem_any) && mem_fast_q ##1 mem_ack_q);
  c_half_route: cover property (!full && !mixed && dma_ch3_req_q);

endmodule

// [cpu_bus_model.sv]
// local processor bus master that runs one memory access at a time against the glue
module cpu_bus_model (
  // clock
  input  wire logic        sys_clk,
  // memory pacing from the glue
  input  wire logic [3:0]  mem_sel_hi_q,
  input  wire logic [3:0]  mem_sel_lo_q,
  input  wire logic        mem_ack_q,
  // local bus
  output logic      [23:1] cpu_addr,
  output logic             cpu_strobe,
  output logic             cpu_upper,
  output logic             cpu_lower
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cpu_addr   = '0;
    cpu_strobe = 1'b0;
    cpu_upper  = 1'b0;
    cpu_lower  = 1'b0;
  end

  // lat counts edges from strobe to acknowledge; 10 means none came
  // rel holds any select seen one edge after release and the ack one edge later
  task automatic access(input logic [23:1] a, input logic u, input logic l,
                        output int lat, output logic [7:0] sel, output logic [7:0] rel);
    @(posedge sys_clk);
    cpu_addr   <= a;
    cpu_upper  <= u;
    cpu_lower  <= l;
    cpu_strobe <= 1'b1;
    lat = 0;
    sel = '0;
    do begin
      @(posedge sys_clk);
      #1;
      lat++;
      if (lat == 1)
        sel = {mem_sel_hi_q, mem_sel_lo_q};
    end while (!mem_ack_q && lat < 10);
    // released address shows its inverse so nothing can lean on a stale value
    @(posedge sys_clk);
    cpu_strobe <= 1'b0;
    cpu_upper  <= 1'b0;
    cpu_lower  <= 1'b0;
    cpu_addr   <= ~a;
    @(posedge sys_clk);
    #1;
    rel = {7'h00, |{mem_sel_hi_q, mem_sel_lo_q}};
    @(posedge sys_clk);
    #1;
    rel[1] = mem_ack_q;
  endtask
endmodule

// [mem_wait_timer.sv]
// wait-cycle counter that paces the local memory acknowledge
module mem_wait_timer
  import strap_glue_pkg::*;
#(
  parameter int DELAY = SLOW_ACK_CYCLES
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // select and timing choice
  input  wire logic mem_sel,
  input  wire logic fast,
  // pacing
  output logic      ack_q,
  output logic      busy_q
);

  localparam int CW = $clog2(DELAY + 1);
  localparam logic [CW-1:0] LAST = CW'(DELAY - 1);

  logic [CW-1:0] cnt_q;

  // counter runs only while select is held
  always_ff @(posedge sys_clk) begin
    if (rst || !mem_sel) begin
      cnt_q <= '0;
    end else if (cnt_q != LAST) begin
      cnt_q <= cnt_q + CW'(1);
    end
  end

  // fast: next edge after select, slow: DELAY edges after select
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= mem_sel && (fast || cnt_q == LAST);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= mem_sel;
    end
  end

endmodule

// [strap_glue_pkg.sv]
// constants shared by the strap glue logic and its wait-cycle timer
package strap_glue_pkg;

  // ************************************************************
  // register map on the plain register port
  // ************************************************************
  localparam logic [3:0] REG_CTRL      = 4'h0;
  localparam logic [3:0] REG_STATUS    = 4'h4;
  localparam logic [3:0] REG_AM_STRAPS = 4'h8;
  localparam logic [7:0] CTRL_RESET    = 8'h01;

  // control fields
  localparam int CTRL_SLAVE_EN   = 0;
  localparam int CTRL_FORCE_SLOW = 1;

  // status fields
  localparam int ST_RESET_PROP = 0;
  localparam int ST_DMA_FULL   = 1;
  localparam int ST_DMA_MIXED  = 2;
  localparam int ST_RAM_FAST   = 3;
  localparam int ST_EPROM_FAST = 4;
  localparam int ST_MEM_BUSY   = 5;
  localparam int ST_SLAVE_SEL  = 6;

  // ************************************************************
  // strap encodings (pulled up, a fitted jumper pulls low)
  // ************************************************************
  localparam logic [1:0] AM_STRAP_LOW  = 2'b00;
  localparam logic [1:0] AM_STRAP_ANY  = 2'b01;
  localparam logic [1:0] AM_STRAP_OPEN = 2'b11;
  localparam int         WAIT_RAM_BIT   = 0;
  localparam int         WAIT_EPROM_BIT = 1;

  // ************************************************************
  // address modifier and memory layout
  // ************************************************************
  localparam logic [2:0] AM_UPPER_STD   = 3'b111;
  localparam logic [1:0] AM_LOW_BLOCK   = 2'b11;
  localparam logic [1:0] AM_LOW_MULTI   = 2'b00;
  localparam int         EPROM_TIER_BIT = 17;
  localparam int         RAM_TIER_BIT   = 16;

  // slow access: acknowledge four processor clocks after select
  localparam int SLOW_ACK_CYCLES = 4;

endpackage

// [test_board_strap_glue.sv]
// self-checking bench for the strap glue logic against a behavioural model
module test_board_strap_glue;
  timeunit 1ns;
  timeprecision 1ps;
  import strap_glue_pkg::*;

  // ************************************************************
  // stimulus and observed signals
  // ************************************************************
  logic        sys_clk  = 1'b0;
  logic        rst      = 1'b1;
  logic        prop     = 1'b1;
  logic [5:0]  am_st    = 6'h07;
  logic [1:0]  wait_st  = 2'h3;
  logic        rt1      = 1'b1;
  logic        rt2      = 1'b1;
  logic        lrst     = 1'b0;
  logic        hit      = 1'b0;
  logic [5:0]  am       = 6'h00;
  logic [2:0]  sreq     = 3'h0;
  logic [1:0]  dack     = 2'h0;
  logic [3:0]  ra       = 4'h0;
  logic [7:0]  wd       = 8'h00;
  logic        wr       = 1'b0;
  logic        rd       = 1'b0;
  logic        en       = 1'b1;
  logic [23:1] ca;
  logic        cs, cu, cl, brst, dsel, ack, c2r, c3r, arx, atx, bak, f, m;
  logic [3:0]  shi, slo, oh;
  logic [1:0]  ln;
  logic [7:0]  rdq, v, sel, rel;
  logic [5:0]  sq[$] = '{6'h13, 6'h3F, 6'h10, 6'h2A, 6'h07};
  int          bases[5] = '{32'h0000_0000, 32'h0002_0000, 32'h0004_0000, 32'h0005_0000,
                            32'h0006_0000};
  int          fails = 0;
  int          n_checks = 0;
  int          seed = 23;
  int          lat, el;

  always #5 sys_clk = ~sys_clk;

  board_strap_glue u_board_strap_glue (
    .sys_clk(sys_clk), .rst(rst), .bus_reset_propagate_strap(prop),
    .modifier_match_straps(am_st), .memory_wait_straps(wait_st),
    .dma_route_strap_first(rt1), .dma_route_strap_second(rt2),
    .local_reset_req(lrst), .bus_reset_q(brst), .vme_addr_hit(hit), .vme_am(am),
    .dpram_sel_q(dsel), .cpu_addr(ca), .cpu_strobe(cs), .cpu_upper(cu), .cpu_lower(cl),
    .mem_sel_hi_q(shi), .mem_sel_lo_q(slo), .mem_ack_q(ack),
    .ser_a_rx_req(sreq[0]), .ser_a_tx_req(sreq[1]), .ser_b_req(sreq[2]),
    .dma_ch2_ack(dack[0]), .dma_ch3_ack(dack[1]), .dma_ch2_req_q(c2r), .dma_ch3_req_q(c3r),
    .ser_a_rx_ack_q(arx), .ser_a_tx_ack_q(atx), .ser_b_ack_q(bak),
    .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr), .reg_rd(rd), .reg_rdata_q(rdq));

  cpu_bus_model u_cpu_bus_model (
    .sys_clk(sys_clk), .mem_sel_hi_q(shi), .mem_sel_lo_q(slo), .mem_ack_q(ack),
    .cpu_addr(ca), .cpu_strobe(cs), .cpu_upper(cu), .cpu_lower(cl));

  // ************************************************************
  // reference model and helpers
  // ************************************************************
  function automatic logic am_ok(logic [5:0] c, logic [5:0] s, logic h, logic e);
    am_ok = h && e && c[5:3] == AM_UPPER_STD && c[1:0] != AM_LOW_BLOCK && c[1:0] != AM_LOW_MULTI;
    for (int i = 0; i < 3; i++) begin
      if (s[2*i+:2] == AM_STRAP_LOW && c[i])
        am_ok = 1'b0;
      else if (s[2*i+1] && !c[i])
        am_ok = 1'b0;
    end
  endfunction

  // outputs packed as ch2 req, ch3 req, port A rx ack, port A tx ack, port B ack
  function automatic logic [4:0] dma_exp(logic a, logic b, logic [2:0] q, logic [1:0] k);
    if (a != b)
      return 5'h00;
    if (a)
      return {q[0], q[1], k[0], k[1], 1'b0};
    return {q[0], q[2], k[0], 1'b0, k[1]};
  endfunction

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    ra <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge sys_clk);
    wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    ra <= a;
    rd <= 1'b1;
    @(posedge sys_clk);
    rd <= 1'b0;
    #1;
    d = rdq;
  endtask

  // straps and levels pass two sync flops and an output register
  task automatic settle();
    repeat (4) @(posedge sys_clk);
    #1;
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #200us;
    fails++;
    give_verdict();
  end

  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    repeat (16) @(posedge sys_clk);
    #1;
    chk("bus_reset", 8'h01, 8'(brst));
    @(posedge sys_clk);
    rst <= 1'b0;
    for (int p = 0; p < 2; p++) begin
      @(posedge sys_clk);
      prop <= p[0];
      lrst <= 1'b1;
      settle();
      chk("bus_reset", 8'(p), 8'(brst));
      @(posedge sys_clk);
      lrst <= 1'b0;
      settle();
      chk("bus_reset", 8'h00, 8'(brst));
    end
    reg_read(REG_CTRL, v);
    chk("ctrl", CTRL_RESET, v);
    reg_write(4'hC, 8'hFF);
    reg_read(4'hC, v);
    chk("unmapped", 8'h00, v);
    // first strap set is ignore, low, high on lines 2..0; last runs with the slave disabled
    sq[3] = 6'($random(seed));
    foreach (sq[k]) begin
      if (k == sq.size() - 1) begin
        reg_write(REG_CTRL, 8'h00);
        en = 1'b0;
      end
      @(posedge sys_clk);
      am_st <= sq[k];
      settle();
      reg_read(REG_AM_STRAPS, v);
      chk("am_straps", {2'b00, sq[k]}, v);
      for (int c = 0; c < 64; c++) begin
        @(posedge sys_clk);
        am  <= 6'(c);
        hit <= ($random(seed) & 3) != 0;
        settle();
        chk("dpram_sel", 8'(am_ok(am, am_st, hit, en)), 8'(dsel));
      end
    end
    // pass 4 keeps both timing straps fitted but forces slow timing from control
    for (int w = 0; w < 5; w++) begin
      if (w == 4)
        reg_write(REG_CTRL, 8'h03);
      @(posedge sys_clk);
      wait_st <= 2'(w);
      settle();
      for (int b = 0; b < 5; b++) begin
        ln = 2'($random(seed));
        u_cpu_bus_model.access(23'((bases[b] + ($random(seed) & 32'h0000_FFFE)) >> 1),
                               ln[1], ln[0], lat, sel, rel);
        f  = (b < 2) ? !wait_st[WAIT_EPROM_BIT] : !wait_st[WAIT_RAM_BIT];
        m  = b < 4 && ln != 2'b00;
        el = !m ? 10 : (f && w != 4) ? 2 : 1 + SLOW_ACK_CYCLES;
        oh = m ? 4'(1 << b) : 4'h0;
        chk("mem_sel", {ln[1] ? oh : 4'h0, ln[0] ? oh : 4'h0}, sel);
        chk("ack_wait", 8'(el), 8'(lat));
        if (m)
          chk("release", 8'h00, rel);
      end
    end
    reg_write(REG_CTRL, CTRL_RESET);
    for (int r = 0; r < 4; r++) begin
      @(posedge sys_clk);
      rt1 <= r[0];
      rt2 <= r[1];
      settle();
      reg_read(REG_STATUS, v);
      // memory idle and a block code left on the modifier lines, so busy and select read 0
      chk("status", {3'b000, ~wait_st, rt1 != rt2, rt1 & rt2, prop}, v);
      repeat (8) begin
        @(posedge sys_clk);
        sreq <= 3'($random(seed));
        dack <= 2'($random(seed));
        settle();
        chk("dma", 8'(dma_exp(rt1, rt2, sreq, dack)), 8'({c2r, c3r, arx, atx, bak}));
      end
    end
    give_verdict();
  end
endmodule
